// ===== common/cms_pkg.sv
/*
  cms_pkg: shared constants and carrier types for the counter module
  status word block. Assumes a 125 MHz core clock and an APB master.
*/
package cms_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned INIT_TIME_NS  = 8000;
  localparam int unsigned INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLINK_TIME_NS = 2000;
  localparam int unsigned BLINK_CYCLES  = (BLINK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CTRL0    = 8'h04;
  localparam logic [7:0] OFS_SHIFT0   = 8'h08;
  localparam logic [7:0] OFS_SHIFT1   = 8'h0C;
  localparam logic [7:0] OFS_CHCFG    = 8'h10;
  localparam logic [7:0] OFS_FREQ0    = 8'h14;
  localparam logic [7:0] OFS_FREQ1    = 8'h18;
  localparam logic [7:0] OFS_IRQ_STS  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // status word and control fields
  localparam int unsigned STS_TF_BIT = 12;
  localparam int unsigned STS_NR_BIT = 13;
  localparam int unsigned STS_FP_BIT = 14;
  localparam int unsigned STS_PE_BIT = 15;
  localparam int unsigned CTRL_ENH_BIT = 11;

  // channel configuration fields
  localparam int unsigned CFG_MODE_W   = 4;
  localparam int unsigned CFG_PRESC_W  = 3;
  localparam int unsigned CFG_CH_STEP  = 8;
  localparam int unsigned CFG_PRESC_LSB = 4;
  localparam logic [3:0] MODE_FREQ_LO = 4'h5;
  localparam logic [3:0] MODE_FREQ_HI = 4'h7;
  localparam logic [3:0] MODE_MAX     = 4'h7;
  localparam logic [2:0] PRESC_Z16    = 3'h4;

  // decimal shift range
  localparam logic signed [15:0] SHIFT_MIN = -16'sd4;
  localparam logic signed [15:0] SHIFT_MAX = 16'sd2;

  // reset values
  localparam logic [15:0] CTRL0_RST = 16'h0000;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [15:0] CHCFG_RST = 16'h0000;
  localparam logic [3:0]  IRQ_RST   = 4'h0;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cms_apb_req_t;

  typedef struct packed {
    logic red;
    logic green;
  } cms_led_t;
endpackage

// ===== verilog/cms_status_word.sv
/*
  cms_status_word: upper status flags of the counter module status word,
  frequency decimal scaling, indicator drive and an APB register slave.
  Assumes raw frequencies and self-test results come from logic on
  core_clk_in; field power sense is an asynchronous pin.
*/
`timescale 1ns/1ps

module cms_status_word
  import cms_pkg::*;
(
  input  wire logic               core_clk_in,        // 125 MHz clock
  input  wire logic               resetn_in,          // async reset, low
  input  wire logic               ce_in,              // clock enable
  input  wire cms_pkg::cms_apb_req_t apb_in,          // apb request
  output logic                    pready_out,         // apb ready
  output logic [31:0]             prdata_out,         // apb read data
  output logic                    pslverr_out,        // apb error
  input  wire logic               field_power_ok_in,  // 24V module supply sense pin
  input  wire logic               selftest_done_in,   // hardware test finished
  input  wire logic               selftest_pass_in,   // hardware test result
  input  wire logic [11:0]        selftest_code_in,   // failure code
  input  wire logic [1:0][31:0]   freq_raw_in,        // unscaled frequency per channel
  output logic [1:0][31:0]        freq_out,           // scaled frequency per channel
  output cms_pkg::cms_led_t       led_out,            // module indicator
  output logic                    outputs_enable_out, // field outputs allowed
  output logic                    irq_out             // level interrupt
);
  import cms_pkg::*;

  typedef enum logic [4:0] {
    ST_INIT   = 5'b00001,
    ST_RUN    = 5'b00010,
    ST_FATAL  = 5'b00100,
    ST_IDLE   = 5'b01000,
    ST_CFGERR = 5'b10000
  } cms_state_t;

  cms_state_t  state_reg, state_next;
  logic        pwr_meta_reg, pwr_sync_reg;
  logic [15:0] ctrl0_reg, chcfg_reg;
  logic [1:0][15:0] shift_reg;
  logic [3:0]  irq_sts_reg, irq_mask_reg;
  logic        tf_reg, nr_reg, fp_reg, pe_reg;
  logic [11:0] code_reg;
  logic [15:0] init_cnt_reg;
  logic [15:0] blink_cnt_reg;
  logic        blink_reg;

  // apb decode
  wire apb_setup  = apb_in.psel & ~apb_in.penable;
  wire apb_commit = apb_in.psel & apb_in.penable & pready_out;
  wire apb_wr     = apb_commit & apb_in.pwrite;
  wire hit_ctrl0  = apb_in.paddr == OFS_CTRL0;
  wire hit_shift0 = apb_in.paddr == OFS_SHIFT0;
  wire hit_shift1 = apb_in.paddr == OFS_SHIFT1;
  wire hit_chcfg  = apb_in.paddr == OFS_CHCFG;
  wire hit_ists   = apb_in.paddr == OFS_IRQ_STS;
  wire hit_imask  = apb_in.paddr == OFS_IRQ_MASK;
  wire hit_ro     = apb_in.paddr == OFS_STATUS || apb_in.paddr == OFS_FREQ0 ||
                    apb_in.paddr == OFS_FREQ1;
  wire hit_any    = hit_ro | hit_ctrl0 | hit_shift0 | hit_shift1 | hit_chcfg |
                    hit_ists | hit_imask;

  wire test_mode  = ctrl0_reg[15:8] != 8'h00;
  wire enh_on     = ctrl0_reg[CTRL_ENH_BIT];
  wire pwr_ok     = pwr_sync_reg;
  wire init_done  = init_cnt_reg == 16'(INIT_CYCLES) && selftest_done_in;
  wire [15:0] status_word = {pe_reg, fp_reg, nr_reg, tf_reg, code_reg};

  // per-channel configuration checks and scaling
  logic [1:0]  mode_bad, presc_bad, freq_mode;
  logic [1:0][31:0] scaled;

  function automatic logic [31:0] dec_scale(input logic [31:0] raw,
                                            input logic signed [15:0] sh);
    logic [31:0] r;
    r = raw;
    unique case (sh)
      -16'sd4: r = raw / 32'd10000;
      -16'sd3: r = raw / 32'd1000;
      -16'sd2: r = raw / 32'd100;
      -16'sd1: r = raw / 32'd10;
      16'sd1:  r = 32'(raw * 32'd10);
      16'sd2:  r = 32'(raw * 32'd100);
      default: r = raw;
    endcase
    return r;
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      wire [3:0] mode  = chcfg_reg[ch*CFG_CH_STEP +: CFG_MODE_W];
      wire [2:0] presc = chcfg_reg[ch*CFG_CH_STEP + CFG_PRESC_LSB +: CFG_PRESC_W];
      wire signed [15:0] sh = shift_reg[ch];
      wire sh_ok = sh >= SHIFT_MIN && sh <= SHIFT_MAX;
      assign freq_mode[ch] = mode >= MODE_FREQ_LO && mode <= MODE_FREQ_HI;
      assign mode_bad[ch]  = mode > MODE_MAX;
      assign presc_bad[ch] = enh_on && freq_mode[ch] && presc >= PRESC_Z16;
      // always from the raw value, so a new shift never compounds
      assign scaled[ch] = (enh_on && freq_mode[ch] && sh_ok) ?
                          dec_scale(freq_raw_in[ch], sh) : freq_raw_in[ch];
    end
  endgenerate

  wire        cfg_err  = |mode_bad | |presc_bad;
  wire [11:0] cfg_code = {8'h00, 1'b0, |presc_bad, mode_bad};

  // state sequencing; power loss overrides everything but the fatal state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_INIT: begin
        if (!pwr_ok)
          state_next = ST_IDLE;
        else if (init_done && !selftest_pass_in)
          state_next = ST_FATAL;
        else if (init_done && cfg_err)
          state_next = ST_CFGERR;
        else if (init_done)
          state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!pwr_ok)
          state_next = ST_IDLE;
        else if (cfg_err)
          state_next = ST_CFGERR;
      end
      ST_CFGERR: begin
        if (!pwr_ok)
          state_next = ST_IDLE;
        else if (!cfg_err)
          state_next = ST_RUN;
      end
      ST_IDLE: begin
        if (pwr_ok)
          state_next = ST_INIT;
      end
      ST_FATAL: state_next = ST_FATAL;
    endcase
  end

  wire tf_next = state_next == ST_FATAL || test_mode;
  wire nr_next = state_next == ST_INIT;
  wire fp_next = state_next == ST_IDLE;
  wire pe_next = state_next == ST_CFGERR;
  wire [11:0] code_next = state_next == ST_FATAL  ? selftest_code_in :
                          state_next == ST_CFGERR ? cfg_code : 12'h000;
  wire [3:0] flags_next = {pe_next, fp_next, nr_next, tf_next};
  wire [3:0] flag_rise  = flags_next & ~{pe_reg, fp_reg, nr_reg, tf_reg};

  // indicator: red steady on fatal, red flash on test or init,
  // green flash on power or config fault, else steady green
  cms_led_t led_next;
  always_comb begin
    led_next = '{red: 1'b0, green: 1'b1};
    if (state_reg == ST_FATAL)
      led_next = '{red: 1'b1, green: 1'b0};
    else if (state_reg == ST_INIT || test_mode)
      led_next = '{red: blink_reg, green: 1'b0};
    else if (state_reg == ST_IDLE || state_reg == ST_CFGERR)
      led_next = '{red: 1'b0, green: blink_reg};
  end

  wire [3:0] ists_next = (irq_sts_reg & ~((apb_wr && hit_ists) ? apb_in.pwdata[3:0] : 4'h0))
                         | flag_rise;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pwr_meta_reg <= 1'b0;
      pwr_sync_reg <= 1'b0;
    end else if (ce_in) begin
      pwr_meta_reg <= field_power_ok_in;
      pwr_sync_reg <= pwr_meta_reg;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg    <= ST_INIT;
      init_cnt_reg <= 16'h0000;
      tf_reg       <= 1'b0;
      nr_reg       <= 1'b1;
      fp_reg       <= 1'b0;
      pe_reg       <= 1'b0;
      code_reg     <= 12'h000;
    end else if (ce_in) begin
      state_reg    <= state_next;
      if (state_reg != ST_INIT)
        init_cnt_reg <= 16'h0000;
      else if (init_cnt_reg != 16'(INIT_CYCLES))
        init_cnt_reg <= init_cnt_reg + 16'h0001;
      tf_reg       <= tf_next;
      nr_reg       <= nr_next;
      fp_reg       <= fp_next;
      pe_reg       <= pe_next;
      code_reg     <= code_next;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      blink_cnt_reg <= 16'h0000;
      blink_reg     <= 1'b0;
    end else if (ce_in) begin
      if (blink_cnt_reg == 16'(BLINK_CYCLES - 1)) begin
        blink_cnt_reg <= 16'h0000;
        blink_reg     <= ~blink_reg;
      end else begin
        blink_cnt_reg <= blink_cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl0_reg    <= CTRL0_RST;
      shift_reg    <= {SHIFT_RST, SHIFT_RST};
      chcfg_reg    <= CHCFG_RST;
      irq_mask_reg <= IRQ_RST;
      irq_sts_reg  <= IRQ_RST;
    end else if (ce_in) begin
      if (apb_wr && hit_ctrl0)
        ctrl0_reg <= apb_in.pwdata[15:0];
      if (apb_wr && hit_shift0)
        shift_reg[0] <= apb_in.pwdata[15:0];
      if (apb_wr && hit_shift1)
        shift_reg[1] <= apb_in.pwdata[15:0];
      if (apb_wr && hit_chcfg)
        chcfg_reg <= apb_in.pwdata[15:0];
      if (apb_wr && hit_imask)
        irq_mask_reg <= apb_in.pwdata[3:0];
      irq_sts_reg <= ists_next;                             // set beats clear
    end
  end

  // read data is captured at the setup edge, so the answer is one access cycle
  wire [31:0] rd_mux =
    apb_in.paddr == OFS_STATUS  ? {16'h0000, status_word} :
    hit_ctrl0                   ? {16'h0000, ctrl0_reg} :
    hit_shift0                  ? {16'h0000, shift_reg[0]} :
    hit_shift1                  ? {16'h0000, shift_reg[1]} :
    hit_chcfg                   ? {16'h0000, chcfg_reg} :
    apb_in.paddr == OFS_FREQ0   ? freq_out[0] :
    apb_in.paddr == OFS_FREQ1   ? freq_out[1] :
    hit_ists                    ? {28'h0000000, irq_sts_reg} :
    hit_imask                   ? {28'h0000000, irq_mask_reg} : 32'h00000000;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out         <= 1'b0;
      prdata_out         <= 32'h00000000;
      pslverr_out        <= 1'b0;
      freq_out           <= '0;
      led_out            <= '{red: 1'b0, green: 1'b0};
      outputs_enable_out <= 1'b0;
      irq_out            <= 1'b0;
    end else if (ce_in) begin
      pready_out         <= apb_setup;
      if (apb_setup) begin
        prdata_out  <= rd_mux;
        pslverr_out <= ~hit_any;
      end
      freq_out           <= scaled;
      led_out            <= led_next;
      // from the next state so outputs drop in the same edge as the fault flag
      outputs_enable_out <= state_next == ST_RUN && !test_mode;
      irq_out            <= |(ists_next & irq_mask_reg);
    end
  end

  chk_fatal_steady_red: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && state_reg == ST_FATAL) |=> tf_reg && led_out.red && !led_out.green)
    else $error("fatal state without steady red and test flag");

  chk_test_mode_flag: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && ctrl0_reg[15:8] != 8'h00) |=> tf_reg)
    else $error("upper control byte set but test flag low");

  chk_test_mode_exit: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && ctrl0_reg[15:8] == 8'h00 && state_next != ST_FATAL) |=> !tf_reg)
    else $error("test flag stuck after upper byte cleared");

  chk_scale_bypass: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && (!enh_on || !freq_mode[0] || $signed(shift_reg[0]) > SHIFT_MAX ||
     $signed(shift_reg[0]) < SHIFT_MIN)) |=> freq_out[0] == $past(freq_raw_in[0]))
    else $error("channel 0 scaled outside enhance conditions");

  chk_scale_div100: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && enh_on && freq_mode[1] && shift_reg[1] == 16'hFFFE)
    |=> freq_out[1] == $past(freq_raw_in[1]) / 32'd100)
    else $error("channel 1 shift -2 did not divide by 100");

  chk_init_not_ready: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && state_next == ST_INIT) |=> nr_reg && !outputs_enable_out)
    else $error("not-ready flag low during initialization");

  chk_power_idle: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && state_next == ST_IDLE) |=> fp_reg && !outputs_enable_out)
    else $error("power lost but fault flag or outputs wrong");

  chk_cfg_err_code: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && state_next == ST_CFGERR) |=> pe_reg && code_reg == $past(cfg_code))
    else $error("config error without flag or code");

  chk_ready_green: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in && state_reg == ST_RUN && !test_mode) |=> led_out.green && !led_out.red && !nr_reg)
    else $error("running without steady green");

  chk_irq_level: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (ce_in ##1 ce_in) |-> irq_out == |(irq_sts_reg & $past(irq_mask_reg)))
    else $error("interrupt output does not follow masked status");
endmodule // cms_status_word

// ===== test/cms_host_model.sv
/*
  cms_host_model: behavioural host controller that reaches the status word
  block over APB, one transfer per call of xfer.
  Assumes one clock shared with the block and a slave that may add waits.
*/
`timescale 1ns/1ps
module cms_host_model
  import cms_pkg::*;
(
  input  wire logic             clk_in,     // core clock
  input  wire logic             pready_in,  // apb ready
  input  wire logic [31:0]      prdata_in,  // apb read data
  input  wire logic             pslverr_in, // apb error
  output cms_pkg::cms_apb_req_t apb_out     // apb request
);
  import cms_pkg::*;

  initial apb_out = '0;

  // host only issues what the caller asks; enhance bit and prescaler care is the
  // caller's side of the deal
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    apb_out <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_in);
    apb_out.penable <= 1'b1;
    // no fixed latency assumed: hold until ready is seen
    do @(posedge clk_in); while (pready_in !== 1'b1);
    rd = prdata_in;
    err = pslverr_in;
    apb_out <= '0;
  endtask
endmodule // cms_host_model

// ===== test/cms_status_word_bench.sv
/*
  cms_status_word_bench: self-checking bench for the status word block.
  Assumes the host model in cms_host_model and the package constants.
*/
`timescale 1ns/1ps
module cms_status_word_bench;
  import cms_pkg::*;
  logic                core_clk_in;
  logic                resetn_in;
  logic                ce_in;
  logic                pready, pslverr, pwr_ok, st_done, st_pass;
  logic [31:0]         prdata;
  logic [11:0]         st_code;
  logic [1:0][31:0]    raw, fout;
  cms_apb_req_t        apb;
  cms_led_t            led;
  logic                oe, irq;
  int                  num_errors = 0;
  int                  n_checks = 0;
  int                  seed = 26;
  int                  s0, s1;

  cms_status_word DUT (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .apb_in(apb), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
    .field_power_ok_in(pwr_ok), .selftest_done_in(st_done), .selftest_pass_in(st_pass),
    .selftest_code_in(st_code), .freq_raw_in(raw), .freq_out(fout), .led_out(led),
    .outputs_enable_out(oe), .irq_out(irq));
  cms_host_model host (.clk_in(core_clk_in), .pready_in(pready), .prdata_in(prdata),
    .pslverr_in(pslverr), .apb_out(apb));

  always #4 core_clk_in = ~core_clk_in;

  function automatic logic [31:0] scale(input logic [31:0] r, input int sh);
    case (sh)
      -4: return r / 32'd10000;
      -3: return r / 32'd1000;
      -2: return r / 32'd100;
      -1: return r / 32'd10;
      1:  return r * 32'd10;
      2:  return r * 32'd100;
      default: return r;   // out of range means unshifted
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b0, a, 32'h00000000, r, e);
    chk(r & m, exp, "register read");
  endtask
  task automatic do_reset();
    resetn_in <= 1'b0;
    repeat (5) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    // power synchroniser starts low, so the block passes through idle first
    repeat (4) @(posedge core_clk_in);
  endtask
  task automatic wait_init();
    repeat (INIT_CYCLES + 10) @(posedge core_clk_in);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end

  initial begin
    logic [31:0] r;
    logic        e;
    core_clk_in = 1'b0; resetn_in = 1'b0; ce_in = 1'b1; pwr_ok = 1'b1;
    st_done = 1'b1; st_pass = 1'b1; st_code = 12'h000; raw = '0;
    do_reset();
    rd_chk(OFS_STATUS, 32'h00002000, 32'h00002000);
    wait_init();
    rd_chk(OFS_STATUS, 32'h00000000, 32'hFFFFFFFF);
    @(negedge core_clk_in) chk({30'h0, led}, 32'h00000001, "green");
    $display("test init done");
    // ch0 freq mode 5, ch1 freq mode 7, plain prescalers
    wr(OFS_CHCFG, 32'h00000705);
    wr(OFS_CTRL0, 32'h00000800);
    rd_chk(OFS_STATUS, 32'h00001000, 32'hFFFFFFFF);
    @(negedge core_clk_in) chk({30'h0, oe, irq}, 32'h00000000, "test mode outs");
    for (int i = 0; i < 14; i++) begin
      s0 = (i == 0) ? -4 : (i == 1) ? 3 : ($random(seed) & 15) - 6;
      s1 = (i == 0) ? 2 : (i == 1) ? -5 : ($random(seed) & 15) - 6;
      wr(OFS_SHIFT0, {16'h0000, 16'(s0)});
      wr(OFS_SHIFT1, {16'h0000, 16'(s1)});
      @(posedge core_clk_in);
      raw <= (i == 0) ? {32'hFFFFFFFF, 32'h0001E240} : {$random(seed), $random(seed)};
      repeat (2) @(posedge core_clk_in);
      @(negedge core_clk_in) chk(fout[0], scale(raw[0], s0), "freq ch0");
      chk(fout[1], scale(raw[1], s1), "freq ch1");
    end
    // clock enable low must hold the scaled output despite a new raw value
    @(posedge core_clk_in) ce_in <= 1'b0;
    raw <= ~raw;
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in) chk(fout[0], scale(~raw[0], s0), "ce frozen");
    @(posedge core_clk_in) ce_in <= 1'b1;
    wr(OFS_CHCFG, 32'h00000700);
    @(posedge core_clk_in);
    @(negedge core_clk_in) chk(fout[0], raw[0], "non freq mode");
    chk(fout[1], scale(raw[1], s1), "freq mode 7");
    wr(OFS_CTRL0, 32'h00000000);
    rd_chk(OFS_STATUS, 32'h00000000, 32'hFFFFFFFF);
    @(negedge core_clk_in) chk({30'h0, led}, 32'h00000001, "green again");
    chk(fout[1], raw[1], "enhance off");
    $display("test scaling done");
    wr(OFS_IRQ_STS, 32'h0000000F);
    rd_chk(OFS_IRQ_STS, 32'h00000000, 32'h0000000F);
    wr(OFS_IRQ_MASK, 32'h00000008);
    wr(OFS_CHCFG, 32'h00000708);
    rd_chk(OFS_STATUS, 32'h00008001, 32'hFFFFFFFF);
    @(negedge core_clk_in) chk({29'h0, irq, oe, led.red}, 32'h00000004, "cfg err");
    wr(OFS_CHCFG, 32'h00000000);
    rd_chk(OFS_STATUS, 32'h00000000, 32'hFFFFFFFF);
    wr(OFS_IRQ_STS, 32'h00000008);
    rd_chk(OFS_IRQ_STS, 32'h00000000, 32'h0000000F);
    @(negedge core_clk_in) chk({31'h0, irq}, 32'h00000000, "irq cleared");
    host.xfer(1'b0, 8'h40, 32'h00000000, r, e);
    chk({e, r[30:0]}, 32'h80000000, "unmapped");
    wr(OFS_STATUS, 32'h0000FFFF);
    rd_chk(OFS_STATUS, 32'h00000000, 32'hFFFFFFFF);
    $display("test error and irq done");
    @(posedge core_clk_in) pwr_ok <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    rd_chk(OFS_STATUS, 32'h00004000, 32'hFFFFFFFF);
    @(negedge core_clk_in) chk({30'h0, oe, led.red}, 32'h00000000, "power lost");
    @(posedge core_clk_in) pwr_ok <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    rd_chk(OFS_STATUS, 32'h00002000, 32'h00006000);
    wait_init();
    rd_chk(OFS_STATUS, 32'h00000000, 32'hFFFFFFFF);
    $display("test power done");
    st_pass <= 1'b0;
    st_code <= 12'hABC;
    do_reset();
    wait_init();
    rd_chk(OFS_STATUS, 32'h00001ABC, 32'hFFFFFFFF);
    for (int i = 0; i < 3; i++) begin
      repeat (BLINK_CYCLES / 2) @(posedge core_clk_in);
      @(negedge core_clk_in) chk({30'h0, led}, 32'h00000002, "steady red");
    end
    $display("test fatal done");
    give_verdict();
  end
endmodule // cms_status_word_bench
